// file: core/adc_seq_regs.vh
// register map, field positions and codes of the conversion sequencer
// assumes: included by bare name from the core design files
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_TEMP_REF_HIGH 8'h23
`define ADDR_TEMP_REF_LOW 8'h24
`define ADDR_OFFSET_TRIM 8'h2e
`define ADDR_GAIN_TRIM 8'h2f
`define ADDR_CHANNEL_SEL 8'he4
`define ADDR_RESULT_HIGH 8'he5
`define ADDR_RESULT_LOW 8'he6
`define ADDR_STATUS 8'he7
`define ADDR_CONTROL 8'he8

// ****************************************
// converter_control fields
// ****************************************
`define CTL_GO 0
`define CTL_ONE_SHOT 1
`define CTL_SCAN 2
`define CTL_BUF_ON 3
`define CTL_DONE_MASK 7

// ****************************************
// channel_select fields
// ****************************************
`define CHSEL_CONV_HI 2
`define CHSEL_CONV_LO 0
`define CHSEL_READ_HI 6
`define CHSEL_READ_LO 4

// ****************************************
// converter_status fields
// ****************************************
`define STAT_DONE 7
`define STAT_BUSY 0

// ****************************************
// reset values
// ****************************************
`define CTL_RESET 1'b0
`define CHSEL_RESET 3'h0
`define RES_RESET 14'h0000
`define BYTE_ZERO 8'h00
`define IRQ_RESET 1'b1

// ****************************************
// result word layout
// ****************************************
`define RES_W 14
`define RES_HIGH_HI 13
`define RES_HIGH_LO 6
`define RES_LOW_HI 5
`define RES_LOW_PAD 2'h0
`define TEMP_HIGH_HI 11
`define TEMP_HIGH_LO 8
`define TEMP_LOW_HI 7
`define TEMP_HIGH_PAD 4'h0
`define GAIN_MASK 8'h3f

// ****************************************
// channel codes
// ****************************************
`define CH_INPUT_CURRENT 3'h0
`define CH_INPUT_VOLTAGE 3'h1
`define CH_STORAGE_VOLTAGE 3'h2
`define CH_OUTPUT_VOLTAGE 3'h3
`define CH_DIE_TEMP 3'h4
`define CH_BUCK1_OUTPUT 3'h5
`define CH_GPIO_IN1 3'h6
`define CH_GPIO_IN2 3'h7
`define CH_STEP 3'h1
`define NUM_CH 8

`endif

// file: core/adc_result_slot.v
// one stored conversion result for a single source
// assumes: load pulse and data come from the sequencer, same clock
`timescale 1ns/100ps
`include "adc_seq_regs.vh"

module adc_result_slot
(
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// new result
	input wire i_load,
	input wire [`RES_W-1:0] i_data,
	// stored result
	output reg [`RES_W-1:0] o_data
);

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_data <= `RES_RESET;
		else if (i_load)
			o_data <= i_data;
	end

endmodule // adc_result_slot

// file: core/adc_conversion_sequencer.v
// conversion sequencer and result registers of the monitoring converter
// assumes: register port driven by the serial register slave, one
// access per pulse; modulator reports done with its result word
//
// Summary of operation
// - one of eight sources converted, 12-bit result
// - eight result registers, one shown by selector
// - go bit starts/stops; single or polling mode
// - convert and readback channel fields, 3 bits
// - writing go=1 while idle starts converting selected source, or source 0 in scan mode
// - finish sets done, interrupt low, go cleared in single mode
// - upper 8 bits, lower 6 bits in two registers
// - done and interrupt held until result read
// - scan mode converts and stores all sources
// - channel codes 000..111 map fixed source order
// - value is 16*high plus low bits 5:2
// - offset and gain trims, sign-magnitude, readable
// - 25 C temperature reference split 4+8 bits
// - done interrupt can be masked
`timescale 1ns/100ps
`include "adc_seq_regs.vh"

module adc_conversion_sequencer
(
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// register port
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_rd,
	output reg [7:0] o_reg_rdata,
	// factory calibration values
	input wire [7:0] i_offset_trim,
	input wire [7:0] i_gain_trim,
	input wire [11:0] i_temp_ref,
	// converter front end
	output reg o_conv_start,
	output reg [2:0] o_conv_channel,
	output reg o_input_buffer_on,
	input wire i_conv_done,
	input wire [`RES_W-1:0] i_conv_data,
	// host interrupt
	output reg o_host_interrupt_n
);

	// ****************************************
	// states
	// ****************************************
	localparam [0:0] ST_IDLE = 1'b0;
	localparam [0:0] ST_BUSY = 1'b1;

	// ****************************************
	// declarations
	// ****************************************
	reg state;
	reg go;
	reg one_shot;
	reg all_channel_scan;
	reg done_mask;
	reg [2:0] convert_channel_sel;
	reg [2:0] readback_channel_sel;
	reg conv_done_flag;
	reg scan_run;
	reg [2:0] conv_chan;
	reg [7:0] next_rdata;
	reg [`RES_W-1:0] shown_result;
	wire [`RES_W*`NUM_CH-1:0] slot_bus;
	wire wr_control;
	wire wr_chsel;
	wire rd_result;
	wire go_req;
	wire stop_req;
	wire finish;
	wire scan_last;
	wire chan_done;
	wire busy;

	// ****************************************
	// access decode
	// ****************************************
	assign wr_control = i_reg_wr && (i_reg_addr == `ADDR_CONTROL);
	assign wr_chsel = i_reg_wr && (i_reg_addr == `ADDR_CHANNEL_SEL);
	// either data register counts as reading the result
	assign rd_result = i_reg_rd
		&& ((i_reg_addr == `ADDR_RESULT_HIGH)
		|| (i_reg_addr == `ADDR_RESULT_LOW));
	assign go_req = wr_control && i_reg_wdata[`CTL_GO];
	// go=0 while idle is harmless; while busy it ends the run
	assign stop_req = wr_control && !i_reg_wdata[`CTL_GO];

	// ****************************************
	// sequencing terms
	// ****************************************
	assign busy = (state == ST_BUSY);
	assign chan_done = busy && i_conv_done;
	// scan ends on the highest channel code
	assign scan_last = (conv_chan == `CH_GPIO_IN2);
	// a stop written in the finishing cycle wins, so no done is raised
	assign finish = chan_done && !stop_req
		&& (!scan_run || scan_last);

	// ****************************************
	// mode and field registers
	// ****************************************
	// mode bits follow every control write, busy or not
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			one_shot <= `CTL_RESET;
			all_channel_scan <= `CTL_RESET;
			o_input_buffer_on <= `CTL_RESET;
			done_mask <= `CTL_RESET;
		end
		else if (wr_control)
		begin
			one_shot <= i_reg_wdata[`CTL_ONE_SHOT];
			all_channel_scan <= i_reg_wdata[`CTL_SCAN];
			o_input_buffer_on <= i_reg_wdata[`CTL_BUF_ON];
			done_mask <= i_reg_wdata[`CTL_DONE_MASK];
		end
	end

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			convert_channel_sel <= `CHSEL_RESET;
			readback_channel_sel <= `CHSEL_RESET;
		end
		else if (wr_chsel)
		begin
			// both fields are independent; host keeps them equal
			convert_channel_sel <=
				i_reg_wdata[`CHSEL_CONV_HI:`CHSEL_CONV_LO];
			readback_channel_sel <=
				i_reg_wdata[`CHSEL_READ_HI:`CHSEL_READ_LO];
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= ST_IDLE;
			go <= `CTL_RESET;
			conv_chan <= `CHSEL_RESET;
			scan_run <= `CTL_RESET;
			o_conv_start <= `CTL_RESET;
			o_conv_channel <= `CHSEL_RESET;
		end
		else
		begin
			o_conv_start <= `CTL_RESET;
			case (state)
				ST_IDLE:
				begin
					if (go_req)
					begin
						go <= 1'b1;
						state <= ST_BUSY;
						o_conv_start <= 1'b1;
						// the run keeps the scan choice of this write
						scan_run <= i_reg_wdata[`CTL_SCAN];
						// the scan bit of the go write picks source 0 or the convert field
						if (i_reg_wdata[`CTL_SCAN])
						begin
							conv_chan <= `CH_INPUT_CURRENT;
							o_conv_channel <= `CH_INPUT_CURRENT;
						end
						else
						begin
							conv_chan <= convert_channel_sel;
							o_conv_channel <= convert_channel_sel;
						end
					end
				end
				ST_BUSY:
				begin
					if (stop_req)
					begin
						go <= 1'b0;
						state <= ST_IDLE;
					end
					else if (chan_done)
					begin
						if (scan_run && !scan_last)
						begin
							conv_chan <= conv_chan + `CH_STEP;
							o_conv_channel <= conv_chan + `CH_STEP;
							o_conv_start <= 1'b1;
						end
						else if (one_shot)
						begin
							go <= 1'b0;
							state <= ST_IDLE;
						end
						else if (scan_run)
						begin
							// polling a scan walks every source again
							conv_chan <= `CH_INPUT_CURRENT;
							o_conv_channel <= `CH_INPUT_CURRENT;
							o_conv_start <= 1'b1;
						end
						else
						begin
							// polling: follow the field as it stands now
							conv_chan <= convert_channel_sel;
							o_conv_channel <= convert_channel_sel;
							o_conv_start <= 1'b1;
						end
					end
					// a go=1 rewrite here changes nothing
				end
				default:
				begin
					state <= ST_IDLE;
					go <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// result storage
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CH; gi = gi + 1)
		begin : g_slot
			// a stop in the done cycle still keeps the word; only the flag is held
			wire load;
			assign load = chan_done && (conv_chan == gi);
			adc_result_slot u_slot
			(
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_load(load),
				.i_data(i_conv_data),
				.o_data(slot_bus[gi*`RES_W +: `RES_W])
			);
		end
	endgenerate

	// eight-to-one selector toward the register map
	always @*
	begin
		shown_result = slot_bus[readback_channel_sel*`RES_W +: `RES_W];
	end

	// ****************************************
	// done flag and interrupt
	// ****************************************
	// the flag still sets while masked; only the interrupt is hidden
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			conv_done_flag <= `CTL_RESET;
		else if (finish)
			conv_done_flag <= 1'b1;
		else if (rd_result)
			conv_done_flag <= 1'b0;
	end

	// set wins over the read-clear so a fresh result is never missed
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_host_interrupt_n <= `IRQ_RESET;
		else
			o_host_interrupt_n <= !((finish
				|| (conv_done_flag && !rd_result))
				&& !done_mask);
	end

	// ****************************************
	// read data
	// ****************************************
	always @*
	begin
		next_rdata = `BYTE_ZERO;
		case (i_reg_addr)
			`ADDR_TEMP_REF_HIGH:
				next_rdata = {`TEMP_HIGH_PAD,
					i_temp_ref[`TEMP_HIGH_HI:`TEMP_HIGH_LO]};
			`ADDR_TEMP_REF_LOW:
				next_rdata = i_temp_ref[`TEMP_LOW_HI:0];
			`ADDR_OFFSET_TRIM:
				next_rdata = i_offset_trim;
			`ADDR_GAIN_TRIM:
				next_rdata = i_gain_trim & `GAIN_MASK;
			`ADDR_CHANNEL_SEL:
			begin
				next_rdata[`CHSEL_CONV_HI:`CHSEL_CONV_LO] =
					convert_channel_sel;
				next_rdata[`CHSEL_READ_HI:`CHSEL_READ_LO] =
					readback_channel_sel;
			end
			// low two bits of the word are carried, host drops them
			`ADDR_RESULT_HIGH:
				next_rdata =
					shown_result[`RES_HIGH_HI:`RES_HIGH_LO];
			`ADDR_RESULT_LOW:
				next_rdata = {`RES_LOW_PAD,
					shown_result[`RES_LOW_HI:0]};
			`ADDR_STATUS:
			begin
				next_rdata[`STAT_DONE] = conv_done_flag;
				next_rdata[`STAT_BUSY] = busy;
			end
			`ADDR_CONTROL:
			begin
				next_rdata[`CTL_GO] = go;
				next_rdata[`CTL_ONE_SHOT] = one_shot;
				next_rdata[`CTL_SCAN] = all_channel_scan;
				next_rdata[`CTL_BUF_ON] = o_input_buffer_on;
				next_rdata[`CTL_DONE_MASK] = done_mask;
			end
			default:
				next_rdata = `BYTE_ZERO;
		endcase
	end

	// read data stands between reads, so a slow host may take it late
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_reg_rdata <= `BYTE_ZERO;
		else if (i_reg_rd)
			o_reg_rdata <= next_rdata;
	end

endmodule // adc_conversion_sequencer

// file: bench/adc_seq_monitor.sv
// assertions on the sequencer ports
// assumes: bound to adc_conversion_sequencer, one clock domain
`timescale 1ns/100ps
`include "adc_seq_regs.vh"
module adc_seq_monitor
(
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// register port
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_rd,
	input wire [7:0] o_reg_rdata,
	// core side
	input wire [7:0] i_gain_trim,
	input wire [11:0] i_temp_ref,
	input wire o_conv_start,
	input wire o_input_buffer_on,
	input wire i_conv_done,
	input wire o_host_interrupt_n
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// a done in the read cycle wins, so it is left out
	sequence s_clr;
		!o_host_interrupt_n && i_reg_rd && i_reg_addr == `ADDR_RESULT_HIGH && !i_conv_done;
	endsequence
	sequence s_hold;
		!o_host_interrupt_n && !i_reg_rd && !i_reg_wr;
	endsequence
	a_irq_cause: assert property ($fell(o_host_interrupt_n) |-> $past(i_conv_done))
		else $error("interrupt fell without a done");
	a_irq_hold: assert property (s_hold |=> !o_host_interrupt_n)
		else $error("interrupt released without a read");
	a_irq_release: assert property (s_clr |=> o_host_interrupt_n)
		else $error("interrupt kept after result read");
	a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
		else $error("start longer than one cycle");
	a_start_cause: assert property ($rose(o_conv_start) |-> $past(i_reg_wr) || $past(i_conv_done))
		else $error("start without write or done");
	a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");
	a_buf_on: assert property (i_reg_wr && i_reg_addr == `ADDR_CONTROL && i_reg_wdata[`CTL_BUF_ON] |=> o_input_buffer_on)
		else $error("buffer enable not taken");
	a_gain_read: assert property (i_reg_rd && i_reg_addr == `ADDR_GAIN_TRIM |=> o_reg_rdata == (i_gain_trim & `GAIN_MASK))
		else $error("gain trim read wrong");
	a_temp_read: assert property (i_reg_rd && i_reg_addr == `ADDR_TEMP_REF_HIGH |=> o_reg_rdata == {4'h0, i_temp_ref[11:8]})
		else $error("temperature reference read wrong");
endmodule // adc_seq_monitor

// file: bench/adc_front_end_model.sv
// converter front end: answers each start after i_delay cycles
// assumes: start pulses from the sequencer on the same clock
`timescale 1ns/100ps
module adc_front_end_model
(
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// control
	input wire i_start,
	input wire [2:0] i_channel,
	input wire [7:0] i_delay,
	// result
	output reg o_done,
	output reg [13:0] o_data
);
	reg [7:0] cnt;
	reg [2:0] ch;
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt <= 8'h00;
			ch <= 3'h0;
			o_done <= 1'b0;
			o_data <= 14'h0000;
		end
		else
		begin
			o_done <= i_start ? 1'b0 : (cnt == 8'h01);
			// word names its source and delay; invalid data toggles
			o_data <= (!i_start && cnt == 8'h01) ? {ch, i_delay, 3'h5} : ~o_data;
			if (i_start)
			begin
				cnt <= i_delay;
				ch <= i_channel;
			end
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
endmodule // adc_front_end_model

// file: bench/tb_adc_conversion_sequencer.sv
// self-checking bench of the conversion sequencer
// assumes: front end model answers each start after dly cycles
`timescale 1ns/100ps
`include "adc_seq_regs.vh"
module tb_adc_conversion_sequencer;
	logic clk, rst_n, wr_s, rd_s, start, bufon, done, irq_n;
	logic [7:0] addr, wdata, rdata, dly;
	logic [2:0] chan;
	logic [13:0] data;
	int mismatches, checks, starts, s0, i;
	adc_conversion_sequencer i_adc_conversion_sequencer (.i_clk(clk), .i_rst_n(rst_n),
		.i_reg_addr(addr), .i_reg_wr(wr_s), .i_reg_wdata(wdata), .i_reg_rd(rd_s),
		.o_reg_rdata(rdata), .i_offset_trim(8'h85), .i_gain_trim(8'hff),
		.i_temp_ref(12'ha3c), .o_conv_start(start), .o_conv_channel(chan),
		.o_input_buffer_on(bufon), .i_conv_done(done), .i_conv_data(data),
		.o_host_interrupt_n(irq_n));
	adc_front_end_model i_adc_front_end_model (.i_clk(clk), .i_rst_n(rst_n),
		.i_start(start), .i_channel(chan), .i_delay(dly), .o_done(done), .o_data(data));
	function logic [13:0] res(input int c, input logic [7:0] d);
		res = {c[2:0], d, 3'h5};
	endfunction
	task test_done;
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		#1;
		cmp(rdata, e);
	endtask
	// bounded wait for a front end done, then one edge for the flag
	task wdone;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 300)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 300)
		begin
			mismatches++;
			test_done;
		end
		@(posedge clk);
		#1;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (start === 1'b1)
			starts <= starts + 1;
	initial
	begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_s = 1'b0;
		rd_s = 1'b0;
		dly = 8'h03;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdc(`ADDR_STATUS, 16'h0000);
		rdc(8'h10, 16'h0000);
		rdc(`ADDR_OFFSET_TRIM, 16'h0085);
		rdc(`ADDR_GAIN_TRIM, 16'h003f);
		rdc(`ADDR_TEMP_REF_HIGH, 16'h000a);
		rdc(`ADDR_TEMP_REF_LOW, 16'h003c);
		for (i = 0; i < 8; i++)
		begin
			wr(`ADDR_CHANNEL_SEL, {1'b0, i[2:0], 1'b0, i[2:0]});
			wr(`ADDR_CONTROL, 8'h0b);
			wdone;
			cmp(chan, i[15:0]);
			cmp(irq_n, 16'h0000);
			cmp(bufon, 16'h0001);
			rdc(`ADDR_STATUS, 16'h0080);
			rdc(`ADDR_CONTROL, 16'h000a);
			rdc(`ADDR_RESULT_HIGH, res(i, 3) >> 6);
			rdc(`ADDR_RESULT_LOW, res(i, 3) & 14'h3f);
			cmp(irq_n, 16'h0001);
		end
		// slow front end so the second go lands mid conversion
		dly <= 8'h28;
		s0 = starts;
		wr(`ADDR_CONTROL, 8'h0b);
		wr(`ADDR_CONTROL, 8'h0b);
		rdc(`ADDR_STATUS, 16'h0001);
		rdc(`ADDR_CONTROL, 16'h000b);
		wdone;
		cmp(starts - s0, 16'h0001);
		rdc(`ADDR_RESULT_HIGH, res(7, 8'h28) >> 6);
		dly <= 8'h02;
		s0 = starts;
		wr(`ADDR_CONTROL, 8'h0f);
		repeat (8) wdone;
		cmp(starts - s0, 16'h0008);
		cmp(irq_n, 16'h0000);
		wr(`ADDR_CONTROL, 8'h0a);
		for (i = 0; i < 8; i++)
		begin
			wr(`ADDR_CHANNEL_SEL, {1'b0, i[2:0], 4'h0});
			rdc(`ADDR_RESULT_HIGH, res(i, 2) >> 6);
		end
		wr(`ADDR_CONTROL, 8'h8b);
		wdone;
		cmp(irq_n, 16'h0001);
		rdc(`ADDR_STATUS, 16'h0080);
		rdc(`ADDR_RESULT_LOW, res(7, 2) & 14'h3f);
		wr(`ADDR_CONTROL, 8'h09);
		repeat (3) wdone;
		rdc(`ADDR_CONTROL, 16'h0009);
		wr(`ADDR_CONTROL, 8'h08);
		rdc(`ADDR_STATUS, 16'h0080);
		s0 = starts;
		rdc(`ADDR_CONTROL, 16'h0008);
		cmp(starts - s0, 16'h0000);
		// polling scan restarts from the first source, not the convert field
		wr(`ADDR_CHANNEL_SEL, 8'h33);
		wr(`ADDR_CONTROL, 8'h0d);
		repeat (8) wdone;
		cmp(chan, 16'h0000);
		rdc(`ADDR_CONTROL, 16'h000d);
		wr(`ADDR_CONTROL, 8'h00);
		rdc(`ADDR_STATUS, 16'h0080);
		cmp(bufon, 16'h0000);
		test_done;
	end
endmodule // tb_adc_conversion_sequencer
bind adc_conversion_sequencer adc_seq_monitor i_adc_seq_monitor (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
	.i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.i_gain_trim(i_gain_trim), .i_temp_ref(i_temp_ref), .o_conv_start(o_conv_start),
	.o_input_buffer_on(o_input_buffer_on), .i_conv_done(i_conv_done),
	.o_host_interrupt_n(o_host_interrupt_n));
